// [include/adccs_pkg.sv]
package adccs_pkg;

	// register byte addresses on the apb word map
	localparam logic [11:0] ADDR_INPUT_REFERENCE_SELECT   = 12'h000;
	localparam logic [11:0] ADDR_CONVERTER_CONTROL_STATUS = 12'h004;
	localparam logic [11:0] ADDR_RESULT_LOW_BYTE          = 12'h008;
	localparam logic [11:0] ADDR_RESULT_HIGH_BYTE         = 12'h00c;

	// input_reference_select fields
	localparam int REF_SEL_MSB      = 7;
	localparam int REF_SEL_LSB      = 6;
	localparam int LEFT_ADJUST_BIT  = 5;
	localparam int CHAN_SEL_MSB     = 3;
	localparam int CHAN_SEL_LSB     = 0;
	localparam logic [7:0] SELECT_WRITE_MASK = 8'hef;

	// converter_control_status fields
	localparam int ENABLE_BIT       = 7;
	localparam int START_BIT        = 6;
	localparam int FREE_RUN_BIT     = 5;
	localparam int DONE_FLAG_BIT    = 4;
	localparam int IRQ_ENABLE_BIT   = 3;
	localparam int DIV_SEL_MSB      = 2;
	localparam int DIV_SEL_LSB      = 0;

	localparam logic [7:0] SELECT_RESET  = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [9:0] RESULT_RESET  = 10'h000;

	// conversion lengths in converter clock cycles
	localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;
	localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
	// converter clock cycle in which the sample is taken
	localparam logic [4:0] SAMPLE_CYCLE_FIRST  = 5'd13;
	localparam logic [4:0] SAMPLE_CYCLE_NORMAL = 5'd1;

	localparam int RESULT_BITS = 10;
	localparam logic [9:0] FULL_SCALE_CODE = 10'h3ff;

	typedef enum logic [1:0] {
		ADCCS_IDLE     = 2'b00,
		ADCCS_CONVERT  = 2'b01,
		ADCCS_COMPLETE = 2'b11
	} adccs_state_t;

	typedef struct packed {
		logic [1:0] reference_select;
		logic [3:0] channel_select;
		logic       converter_enable;
		logic       sample;
	} adccs_analog_t;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} adccs_apb_req_t;

endpackage

// [verilog/adccs_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
// converter clock tick generator, one core_clk pulse per converter clock
module adccs_prescaler
(
	input  wire logic       core_clk_i,
	input  wire logic       reset_i,
	input  wire logic       run_i,
	input  wire logic [2:0] divider_select_i,
	output logic            tick_o
);
	typedef struct packed {
		logic [6:0] count;
		logic       tick;
	} adccs_div_state_t;

	adccs_div_state_t state;
	adccs_div_state_t next_state;

	function automatic logic [6:0] adccs_div_limit(input logic [2:0] sel);
		case (sel)
			3'h0, 3'h1: adccs_div_limit = 7'h01;
			default:    adccs_div_limit = 7'((8'h01 << sel) - 8'h01);
		endcase
	endfunction

	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		// divider held at zero while idle, so each conversion starts phase-aligned
		if (!run_i)
			next_state.count = 7'h00;
		else if (state.count >= adccs_div_limit(divider_select_i))
		begin
			next_state.count = 7'h00;
			next_state.tick = 1'b1;
		end
		else
			next_state.count = state.count + 7'h01;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign tick_o = state.tick;
endmodule // adccs_prescaler
`default_nettype wire

// [verilog/adccs_result_view.sv]
`timescale 1ns/1ps
`default_nettype none
// presents the 10-bit result as two bytes, left or right adjusted
module adccs_result_view
(
	input  wire logic [9:0] result_i,
	input  wire logic       left_adjust_i,
	output logic      [7:0] low_byte_o,
	output logic      [7:0] high_byte_o
);
	always_comb
	begin
		if (left_adjust_i)
		begin
			high_byte_o = result_i[9:2];
			low_byte_o  = {result_i[1:0], 6'h00};
		end
		else
		begin
			high_byte_o = {6'h00, result_i[9:8]};
			low_byte_o  = result_i[7:0];
		end
	end
endmodule // adccs_result_view
`default_nettype wire

// [verilog/adccs_control.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - result code is input times 1024 over reference; 0x3ff is reference minus one step
// - after done, result stays in low and high byte registers for reading
// - reference select bits 7:6 choose external, supply, reserved, internal reference
// - reference and channel select changes during a conversion take effect only after it completes
// - left adjust bit 5 left-aligns the result; zero right-aligns it
// - left adjust changes the result presentation immediately, even mid-conversion
// - channel select bits 3:0 pick inputs 0-7, bandgap 1110, ground 1111
// - enable bit 7 powers converter; clearing it aborts a conversion
// - writing one to start begins a conversion; free-run needs only first
// - first conversion after enable takes 25 converter clocks, later ones 13
// - start reads one while converting, zero after; writing zero does nothing
// - free-run bit 5 converts continuously; clearing it ends free running
// - done flag bit 4 sets when a conversion completes, whether the result updates or is held
// - interrupt requested only while done, irq enable and global enable set
// - done flag cleared on vector acknowledge or by writing one
// - divider bits 2:0 divide by 2,2,4,8,16,32,64,128
// - irq enable bit 3 enables the completion interrupt with global enable
// - after low byte read, result holds until high byte is read
module adccs_control
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [9:0]  core_code_i,
	input  wire logic        global_irq_enable_i,
	input  wire logic        irq_ack_i,
	output logic             irq_o,
	output adccs_pkg::adccs_analog_t analog_o
);
	typedef struct packed {
		logic [7:0]              select;
		logic [7:0]              control;
		logic [1:0]              active_reference;
		logic [3:0]              active_channel;
		logic [9:0]              result;
		logic [9:0]              pending_result;
		logic                    pending_valid;
		logic                    high_locked;
		logic                    first_pending;
		logic [4:0]              cycle;
		adccs_pkg::adccs_state_t phase;
		logic [31:0]             rdata;
		logic                    ready;
		logic                    slverr;
		logic                    irq;
		adccs_pkg::adccs_analog_t analog;
	} adccs_ctl_state_t;

	adccs_ctl_state_t state;
	adccs_ctl_state_t next_state;

	logic       tick;
	logic [7:0] view_low;
	logic [7:0] view_high;
	logic       access;
	logic       wr;
	logic       rd;
	logic       start_now;
	logic       conv_done;
	logic [4:0] conv_len;
	logic [4:0] sample_at;

	function automatic logic [7:0] adccs_merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic lane);
		adccs_merge = lane ? new_v : old_v;
	endfunction

	adccs_prescaler u_prescaler
	(
		.core_clk_i       (core_clk_i),
		.reset_i          (reset_i),
		.run_i            (state.phase == adccs_pkg::ADCCS_CONVERT),
		.divider_select_i (state.control[adccs_pkg::DIV_SEL_MSB:adccs_pkg::DIV_SEL_LSB]),
		.tick_o           (tick)
	);

	// presentation follows the live left adjust bit, never a latched copy
	adccs_result_view u_view
	(
		.result_i      (state.result),
		.left_adjust_i (state.select[adccs_pkg::LEFT_ADJUST_BIT]),
		.low_byte_o    (view_low),
		.high_byte_o   (view_high)
	);

	assign access    = psel_i && penable_i && !state.ready;
	assign wr        = access && pwrite_i && pstrb_i[0];
	assign rd        = access && !pwrite_i;
	assign conv_len  = state.first_pending ? adccs_pkg::FIRST_CONV_CYCLES
		: adccs_pkg::NORMAL_CONV_CYCLES;
	assign sample_at = state.first_pending ? adccs_pkg::SAMPLE_CYCLE_FIRST
		: adccs_pkg::SAMPLE_CYCLE_NORMAL;
	assign conv_done = (state.phase == adccs_pkg::ADCCS_CONVERT) && tick
		&& (state.cycle == conv_len - 5'd1);

	always_comb
	begin
		logic [7:0] wctl;
		logic       done_set;
		logic [9:0] new_result;
		wctl       = pwdata_i[7:0];
		done_set   = 1'b0;
		new_result = state.pending_result;
		start_now  = 1'b0;
		next_state = state;
		next_state.ready  = access;
		next_state.slverr = 1'b0;
		next_state.analog.sample = 1'b0;

		// register writes
		if (wr && paddr_i == adccs_pkg::ADDR_INPUT_REFERENCE_SELECT)
			next_state.select = pwdata_i[7:0] & adccs_pkg::SELECT_WRITE_MASK;
		if (wr && paddr_i == adccs_pkg::ADDR_CONVERTER_CONTROL_STATUS)
		begin
			next_state.control[adccs_pkg::ENABLE_BIT]     = wctl[adccs_pkg::ENABLE_BIT];
			next_state.control[adccs_pkg::FREE_RUN_BIT]   = wctl[adccs_pkg::FREE_RUN_BIT];
			next_state.control[adccs_pkg::IRQ_ENABLE_BIT] = wctl[adccs_pkg::IRQ_ENABLE_BIT];
			next_state.control[adccs_pkg::DIV_SEL_MSB:adccs_pkg::DIV_SEL_LSB] =
				wctl[adccs_pkg::DIV_SEL_MSB:adccs_pkg::DIV_SEL_LSB];
			if (wctl[adccs_pkg::DONE_FLAG_BIT])
				next_state.control[adccs_pkg::DONE_FLAG_BIT] = 1'b0;
			// enabling from off arms the long first conversion
			if (wctl[adccs_pkg::ENABLE_BIT] && !state.control[adccs_pkg::ENABLE_BIT])
				next_state.first_pending = 1'b1;
			// start written as zero leaves the busy bit alone
			if (wctl[adccs_pkg::START_BIT] && wctl[adccs_pkg::ENABLE_BIT]
				&& state.phase == adccs_pkg::ADCCS_IDLE)
				start_now = 1'b1;
		end
		if (irq_ack_i)
			next_state.control[adccs_pkg::DONE_FLAG_BIT] = 1'b0;

		// high byte read releases the lock taken by the low byte read
		if (rd && paddr_i == adccs_pkg::ADDR_RESULT_LOW_BYTE)
			next_state.high_locked = 1'b1;
		if (rd && paddr_i == adccs_pkg::ADDR_RESULT_HIGH_BYTE)
			next_state.high_locked = 1'b0;

		case (state.phase)
			adccs_pkg::ADCCS_IDLE:
			begin
				next_state.cycle = 5'd0;
			end
			adccs_pkg::ADCCS_CONVERT:
			begin
				if (tick)
				begin
					next_state.cycle = state.cycle + 5'd1;
					if (state.cycle == sample_at)
						next_state.analog.sample = 1'b1;
				end
				if (conv_done)
					next_state.phase = adccs_pkg::ADCCS_COMPLETE;
			end
			adccs_pkg::ADCCS_COMPLETE:
			begin
				// core code taken one cycle after the last converter clock
				new_result = core_code_i;
				done_set   = 1'b1;
				next_state.first_pending = 1'b0;
				next_state.cycle = 5'd0;
				if (state.control[adccs_pkg::FREE_RUN_BIT])
					start_now = 1'b1;
				else
				begin
					next_state.phase = adccs_pkg::ADCCS_IDLE;
					next_state.control[adccs_pkg::START_BIT] = 1'b0;
				end
			end
			default:
				next_state.phase = adccs_pkg::ADCCS_IDLE;
		endcase

		if (done_set)
		begin
			// held while the low byte has been read and the high byte not yet
			if (next_state.high_locked)
			begin
				next_state.pending_result = new_result;
				next_state.pending_valid  = 1'b1;
			end
			else
				next_state.result = new_result;
			next_state.control[adccs_pkg::DONE_FLAG_BIT] = 1'b1;
		end
		else if (state.pending_valid && !next_state.high_locked)
		begin
			next_state.result = state.pending_result;
			next_state.pending_valid = 1'b0;
		end

		if (start_now)
		begin
			next_state.phase = adccs_pkg::ADCCS_CONVERT;
			next_state.control[adccs_pkg::START_BIT] = 1'b1;
			// selections latched only at a start, so mid-conversion writes wait
			next_state.active_reference =
				next_state.select[adccs_pkg::REF_SEL_MSB:adccs_pkg::REF_SEL_LSB];
			next_state.active_channel =
				next_state.select[adccs_pkg::CHAN_SEL_MSB:adccs_pkg::CHAN_SEL_LSB];
		end

		if (!next_state.control[adccs_pkg::ENABLE_BIT])
		begin
			next_state.phase = adccs_pkg::ADCCS_IDLE;
			next_state.control[adccs_pkg::START_BIT] = 1'b0;
			next_state.cycle = 5'd0;
			next_state.analog.sample = 1'b0;
		end

		next_state.analog.converter_enable = next_state.control[adccs_pkg::ENABLE_BIT];
		next_state.analog.reference_select = next_state.active_reference;
		next_state.analog.channel_select   = next_state.active_channel;
		next_state.irq = next_state.control[adccs_pkg::DONE_FLAG_BIT]
			&& next_state.control[adccs_pkg::IRQ_ENABLE_BIT]
			&& global_irq_enable_i;

		// read data and unmapped-address error
		next_state.rdata = 32'h0000_0000;
		if (access)
		begin
			case (paddr_i)
				adccs_pkg::ADDR_INPUT_REFERENCE_SELECT:
					next_state.rdata = {24'h000000, state.select};
				adccs_pkg::ADDR_CONVERTER_CONTROL_STATUS:
					next_state.rdata = {24'h000000, state.control};
				adccs_pkg::ADDR_RESULT_LOW_BYTE:
					next_state.rdata = {24'h000000, view_low};
				adccs_pkg::ADDR_RESULT_HIGH_BYTE:
					next_state.rdata = {24'h000000, view_high};
				default:
					next_state.slverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			state         <= '0;
			state.select  <= adccs_pkg::SELECT_RESET;
			state.control <= adccs_pkg::CONTROL_RESET;
			state.result  <= adccs_pkg::RESULT_RESET;
			state.phase   <= adccs_pkg::ADCCS_IDLE;
		end
		else
			state <= next_state;
	end

	assign prdata_o  = state.rdata;
	assign pready_o  = state.ready;
	assign pslverr_o = state.slverr;
	assign irq_o     = state.irq;
	assign analog_o  = state.analog;
endmodule // adccs_control
`default_nettype wire

// [tb/adccs_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// converter core stand-in: latches a code per channel and reference at the sample pulse
// no external voltage sits on the reference pin here, so every reference code is safe
module adccs_core_model
(
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	input  wire adccs_pkg::adccs_analog_t analog_i,
	output logic                    [9:0] code_o
);
	always_ff @(posedge core_clk_i)
		if (reset_i)
			code_o <= 10'h2aa;
		else if (analog_i.sample)
			code_o <= (analog_i.channel_select == 4'hf) ? 10'h000 :
				{analog_i.channel_select, analog_i.reference_select, 4'h9};
endmodule // adccs_core_model
`default_nettype wire

// [tb/adccs_chk_props.sv]
`timescale 1ns/1ps
`default_nettype none
module adccs_chk
(
	input wire logic        core_clk_i,
	input wire logic        reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        global_irq_enable_i,
	input wire logic        irq_o,
	input wire adccs_pkg::adccs_analog_t analog_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	chk_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("pready late");
	chk_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready held");
	chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("prdata outside answer");
	chk_rdata_width: assert property (prdata_o[31:8] == 24'h0)
		else $error("prdata upper bits");
	chk_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	chk_irq_gie: assert property (irq_o |-> $past(global_irq_enable_i))
		else $error("irq without global enable");
	chk_sample_gap: assert property (analog_o.sample |=> !analog_o.sample [*8])
		else $error("sample pulses too close");
	chk_sel_hold: assert property (analog_o.sample |=>
		$stable({analog_o.reference_select, analog_o.channel_select}) [*8])
		else $error("select moved mid conversion");
	chk_off_quiet: assert property (!analog_o.converter_enable |-> !analog_o.sample)
		else $error("sample while disabled");
endmodule // adccs_chk
bind adccs_control adccs_chk u_chk
(
	.core_clk_i(core_clk_i),
	.reset_i(reset_i),
	.psel_i(psel_i),
	.penable_i(penable_i),
	.prdata_o(prdata_o),
	.pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.global_irq_enable_i(global_irq_enable_i),
	.irq_o(irq_o),
	.analog_o(analog_o)
);
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [11:0] SEL = adccs_pkg::ADDR_INPUT_REFERENCE_SELECT;
	localparam logic [11:0] CTL = adccs_pkg::ADDR_CONVERTER_CONTROL_STATUS;
	localparam logic [11:0] LO  = adccs_pkg::ADDR_RESULT_LOW_BYTE;
	localparam logic [11:0] HI  = adccs_pkg::ADDR_RESULT_HIGH_BYTE;
	logic        core_clk_i, reset_i, psel, penable, pwrite, gie, ack, pready, err, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [9:0]  code, x;
	adccs_pkg::adccs_analog_t ana;
	int          err_total, checks, cyc, n;
	adccs_control DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'h1), .prdata_o(prdata), .pready_o(pready), .pslverr_o(err),
		.core_code_i(code), .global_irq_enable_i(gie), .irq_ack_i(ack), .irq_o(irq),
		.analog_o(ana));
	adccs_core_model u_core (.core_clk_i(core_clk_i), .reset_i(reset_i), .analog_i(ana),
		.code_o(code));
	initial
	begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	function automatic logic [9:0] f(input logic [3:0] c, input logic [1:0] s);
		return (c == 4'hf) ? 10'h000 : {c, s, 4'h9};
	endfunction
	task automatic finish_test;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	// the master waits on pready itself; only the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk_i);
		penable <= 1'b1;
		do @(posedge core_clk_i); while (pready !== 1'b1);
		r = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
		apb(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, r);
	endtask
	task automatic wait_done;
		n = 0;
		do
		begin
			apb(1'b0, CTL, 8'h00);
			n++;
		end
		while (r[4] !== 1'b1 && n < 300);
	endtask
	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			finish_test;
		end
	end
	initial
	begin
		{reset_i, psel, penable, pwrite, paddr, pwdata, gie, ack} = '0;
		reset_i = 1'b1;
		{err_total, checks, cyc} = '0;
		repeat (10) @(posedge core_clk_i);
		reset_i <= 1'b0;
		rd(SEL, 8'h00, "sel_reset");
		rd(CTL, 8'h00, "ctl_reset");
		apb(1'b1, SEL, 8'hff);
		rd(SEL, 8'hef, "sel_bit4");
		apb(1'b0, 12'h010, 8'h00);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, SEL, 8'h43);
		apb(1'b1, CTL, 8'hc2);
		rd(CTL, 8'hc2, "busy");
		apb(1'b1, SEL, 8'h05);
		wait_done;
		chk("done", 32'h92, r);
		chk("conv25", 32'h1, {31'h0, n >= 22 && n <= 26});
		x = f(4'h3, 2'h1);
		rd(LO, x[7:0], "lo_right");
		rd(HI, {6'h0, x[9:8]}, "hi_right");
		apb(1'b1, SEL, 8'h25);
		rd(LO, {x[1:0], 6'h0}, "lo_left");
		rd(HI, x[9:2], "hi_left");
		apb(1'b1, CTL, 8'h82);
		rd(CTL, 8'h92, "start_zero");
		apb(1'b1, CTL, 8'h92);
		rd(CTL, 8'h82, "done_w1c");
		gie <= 1'b1;
		apb(1'b1, CTL, 8'hc8);
		n = 0;
		while (irq !== 1'b1 && n < 100)
		begin
			@(posedge core_clk_i);
			n++;
		end
		chk("conv13", 32'h1, {31'h0, n >= 22 && n <= 32});
		chk("irq", 32'h1, {31'h0, irq});
		gie <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		chk("irq_gie", 32'h0, {31'h0, irq});
		gie <= 1'b1;
		ack <= 1'b1;
		@(posedge core_clk_i);
		ack <= 1'b0;
		rd(CTL, 8'h88, "ack_clear");
		x = f(4'h5, 2'h0);
		rd(HI, x[9:2], "new_select");
		apb(1'b1, CTL, 8'he0);
		wait_done;
		apb(1'b1, CTL, 8'hb0);
		wait_done;
		chk("free_run", 32'hf0, r);
		rd(LO, {x[1:0], 6'h0}, "lo_lock");
		apb(1'b1, SEL, 8'h2e);
		repeat (80) @(posedge core_clk_i);
		rd(HI, x[9:2], "hi_locked");
		x = f(4'he, 2'h0);
		rd(HI, x[9:2], "hi_fresh");
		apb(1'b1, CTL, 8'h90);
		repeat (80) @(posedge core_clk_i);
		rd(CTL, 8'h90, "free_end");
		apb(1'b1, CTL, 8'h97);
		apb(1'b1, CTL, 8'hc7);
		apb(1'b1, CTL, 8'h87);
		rd(CTL, 8'hc7, "busy_hold");
		apb(1'b1, CTL, 8'h07);
		// longer than a full divide-by-128 conversion, so a missed abort would set done
		repeat (1800) @(posedge core_clk_i);
		rd(CTL, 8'h07, "abort");
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
